// ===== sim/pcim_host_model.sv
// host-side model of the parallel interrupt lines
`timescale 1ns/1ps
`default_nettype none
module pcim_host_model
(
  // terminals from the block
  input wire logic [2:0] multifunction_terminals_o,
  input wire logic [2:0] multifunction_terminals_oe,
  // line levels as the host sees them
  output logic [2:0] irq_line_n
);
  // open-drain lines
  // pulled up, so an undriven line reads high, never the last value
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      irq_line_n[i] = multifunction_terminals_oe[i] ? multifunction_terminals_o[i] : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== sim/pcim_irq_ctrl_chk.sv
// port assertions for the card interrupt block
`timescale 1ns/1ps
`default_nettype none
module pcim_irq_ctrl_chk
  import pcim_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // card side
  input wire pcim_card_t card_type,
  input wire pcim_card_sig_t card_sig,
  input wire logic power_up_done,
  // register port
  input wire pcim_reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  // interrupt outputs
  input wire logic [2:0] multifunction_terminals_o,
  input wire logic [2:0] multifunction_terminals_oe,
  input wire logic serial_irq_stream_csc_req,
  input wire logic serial_irq_stream_func_req,
  input wire logic [7:0] interrupt_pin_code_f0,
  input wire logic [7:0] interrupt_pin_code_f1
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire logic ev_rd = reg_req.rd && !reg_req.wr && reg_req.space == SPACE_SOCKET && reg_req.addr == OFS_SOCKET_IRQ_EVENT;
  wire logic dc_wr = reg_req.wr && reg_req.space == SPACE_PCI && reg_req.addr == OFS_DEVICE_CONTROL;
  property p_rd_answer;
    reg_req.rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rdata_hold;
    !reg_rvalid |-> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_pin_f0;
    interrupt_pin_code_f0 == PIN_CODE_A;
  endproperty
  a_pin_f0: assert property (p_pin_f0) else $error("function 0 pin code wrong");
  property p_pin_f1_shared;
    dc_wr && reg_req.wdata[2:1] == 2'b10 |-> ##[1:3] interrupt_pin_code_f1 == PIN_CODE_A;
  endproperty
  a_pin_f1_shared: assert property (p_pin_f1_shared) else $error("function 1 not shared");
  property p_pin_f1_own;
    dc_wr && reg_req.wdata[2:1] != 2'b10 |-> ##[1:3] interrupt_pin_code_f1 == PIN_CODE_B;
  endproperty
  a_pin_f1_own: assert property (p_pin_f1_own) else $error("function 1 pin code wrong");
  property p_force_rd_zero;
    reg_req.rd && reg_req.space == SPACE_SOCKET && reg_req.addr == OFS_SOCKET_FORCE_EVENT |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_force_rd_zero: assert property (p_force_rd_zero) else $error("force event read not zero");
  // a read must never drop an event bit
  property p_event_no_clear;
    ev_rd ##1 ev_rd |=> (reg_rdata & $past(reg_rdata)) == $past(reg_rdata);
  endproperty
  a_event_no_clear: assert property (p_event_no_clear) else $error("read cleared event");
  property p_csc_excl;
    serial_irq_stream_csc_req |-> multifunction_terminals_oe == 3'b000;
  endproperty
  a_csc_excl: assert property (p_csc_excl) else $error("terminal driven in serial mode");
endmodule
bind pcim_irq_ctrl pcim_irq_ctrl_chk chk_u (.core_clk(core_clk), .rstn(rstn), .card_type(card_type),
  .card_sig(card_sig), .power_up_done(power_up_done), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .multifunction_terminals_o(multifunction_terminals_o),
  .multifunction_terminals_oe(multifunction_terminals_oe), .serial_irq_stream_csc_req(serial_irq_stream_csc_req),
  .serial_irq_stream_func_req(serial_irq_stream_func_req), .interrupt_pin_code_f0(interrupt_pin_code_f0),
  .interrupt_pin_code_f1(interrupt_pin_code_f1));
`default_nettype wire

// ===== sim/test_pcim_irq_ctrl.sv
// self-checking bench for the card interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_pcim_irq_ctrl
  import pcim_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  pcim_card_t card_type = CARD_NONE;
  pcim_card_sig_t card_sig = '0;
  logic power_up_done = 1'b0;
  pcim_reg_req_t reg_req = '0;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [2:0] mft_o;
  logic [2:0] mft_oe;
  logic [2:0] irq_line_n;
  logic csc_req;
  logic func_req;
  logic [7:0] pin_f0;
  logic [7:0] pin_f1;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 core_clk = ~core_clk;
  pcim_irq_ctrl dut_u (.core_clk(core_clk), .rstn(rstn), .card_type(card_type), .card_sig(card_sig),
    .power_up_done(power_up_done), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .multifunction_terminals_o(mft_o), .multifunction_terminals_oe(mft_oe),
    .serial_irq_stream_csc_req(csc_req), .serial_irq_stream_func_req(func_req),
    .interrupt_pin_code_f0(pin_f0), .interrupt_pin_code_f1(pin_f1));
  pcim_host_model host_u (.multifunction_terminals_o(mft_o), .multifunction_terminals_oe(mft_oe),
    .irq_line_n(irq_line_n));
  // ****
  // tasks
  // ****
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // request held n edges, released at the last sampling edge
  task acc(input pcim_reg_req_t r, input int n);
    @(posedge core_clk);
    reg_req <= r;
    repeat (n) @(posedge core_clk);
    reg_req <= '0;
    #1;
  endtask
  task wr(input logic [1:0] s, input logic [7:0] a, input logic [31:0] d);
    acc({1'b0, 1'b1, s, a, d}, 1);
  endtask
  task rd(input logic [1:0] s, input logic [7:0] a, input logic [31:0] e, input int n);
    acc({1'b1, 1'b0, s, a, 32'h0000_0000}, n);
    chk(32'(reg_rvalid), 32'h0000_0001);
    chk(reg_rdata, e);
  endtask
  task ev(input pcim_card_sig_t s);
    @(posedge core_clk);
    card_sig <= s;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task pwr;
    @(posedge core_clk);
    power_up_done <= 1'b1;
    @(posedge core_clk);
    power_up_done <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task results;
    $display("compares %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard, far above the roughly 150 cycles the tests need
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      results;
    end
  end
  // ****
  // tests
  // ****
  initial
  begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    rd(SPACE_PCI, OFS_DEVICE_CONTROL, 32'h0000_0006, 1);
    rd(SPACE_LEGACY, OFS_LEGACY_GLOBAL_CONTROL, 32'h0000_0000, 1);
    chk(pin_f1, PIN_CODE_B);
    rd(SPACE_PCI, 8'h55, 32'h0000_0000, 1);
    $display("reset test done");
    for (int m = 0; m < 4; m++)
    begin
      wr(SPACE_PCI, OFS_DEVICE_CONTROL, 32'(m) << MODE_LSB);
      rd(SPACE_PCI, OFS_DEVICE_CONTROL, 32'(m) << MODE_LSB, 1);
      chk(pin_f1, (m == 2) ? PIN_CODE_A : PIN_CODE_B);
      chk(pin_f0, PIN_CODE_A);
    end
    $display("mode test done");
    wr(SPACE_PCI, OFS_DEVICE_CONTROL, 32'h0000_0000);
    @(posedge core_clk);
    card_type <= CARD_MEM16;
    wr(SPACE_LEGACY, OFS_LEGACY_CHANGE_IRQ_CONFIG, 32'h0000_000f);
    ev(8'h80);
    chk(mft_oe, 3'b001);
    chk(irq_line_n, 3'b110);
    ev(8'hc0);
    ev(8'he0);
    pwr();
    rd(SPACE_LEGACY, OFS_LEGACY_CHANGE_FLAGS, 32'h0000_000f, 1);
    rd(SPACE_LEGACY, OFS_LEGACY_CHANGE_FLAGS, 32'h0000_0000, 1);
    chk(mft_oe, 3'b000);
    rd(SPACE_PCI, OFS_CARD_CONTROL, 32'h0000_0000, 1);
    $display("memory card test done");
    wr(SPACE_LEGACY, OFS_LEGACY_GLOBAL_CONTROL, 32'h0000_0004);
    wr(SPACE_LEGACY, OFS_LEGACY_CHANGE_IRQ_CONFIG, 32'h0000_0000);
    ev(8'h60);
    chk(mft_oe, 3'b000);
    rd(SPACE_LEGACY, OFS_LEGACY_CHANGE_FLAGS, 32'h0000_0001, 1);
    rd(SPACE_LEGACY, OFS_LEGACY_CHANGE_FLAGS, 32'h0000_0001, 1);
    wr(SPACE_LEGACY, OFS_LEGACY_CHANGE_FLAGS, 32'h0000_0001);
    rd(SPACE_LEGACY, OFS_LEGACY_CHANGE_FLAGS, 32'h0000_0000, 1);
    $display("clear mode test done");
    @(posedge core_clk);
    card_type <= CARD_IO16;
    ev(8'h50);
    // power up before any functional request
    pwr();
    rd(SPACE_LEGACY, OFS_LEGACY_CHANGE_FLAGS, 32'h0000_0009, 1);
    ev(8'h70);
    rd(SPACE_PCI, OFS_CARD_CONTROL, 32'h0000_0001, 1);
    chk(mft_oe, 3'b010);
    wr(SPACE_PCI, OFS_CARD_CONTROL, 32'h0000_0001);
    rd(SPACE_PCI, OFS_CARD_CONTROL, 32'h0000_0000, 1);
    wr(SPACE_LEGACY, OFS_LEGACY_CHANGE_FLAGS, 32'h0000_0009);
    $display("io card test done");
    @(posedge core_clk);
    card_type <= CARD_CARDBUS;
    // socket and pci registers only from here on
    wr(SPACE_PCI, OFS_IRQ_ROUTE, 32'h0000_0006);
    wr(SPACE_SOCKET, OFS_SOCKET_IRQ_MASK, 32'h0000_000f);
    ev(8'h02);
    rd(SPACE_SOCKET, OFS_SOCKET_IRQ_EVENT, 32'h0000_0002, 2);
    chk(mft_oe, 3'b100);
    wr(SPACE_PCI, OFS_DEVICE_CONTROL, 32'h0000_0006);
    rd(SPACE_PCI, OFS_DEVICE_CONTROL, 32'h0000_0006, 1);
    chk(32'(csc_req), 32'h0000_0001);
    chk(mft_oe, 3'b000);
    wr(SPACE_PCI, OFS_DEVICE_CONTROL, 32'h0000_0000);
    rd(SPACE_SOCKET, OFS_SOCKET_FORCE_EVENT, 32'h0000_0000, 1);
    wr(SPACE_SOCKET, OFS_SOCKET_FORCE_EVENT, 32'h0000_0002);
    rd(SPACE_SOCKET, OFS_SOCKET_IRQ_EVENT, 32'h0000_0000, 1);
    ev(8'h0a);
    pwr();
    rd(SPACE_SOCKET, OFS_SOCKET_IRQ_EVENT, 32'h0000_0009, 1);
    ev(8'h0e);
    rd(SPACE_PCI, OFS_CARD_CONTROL, 32'h0000_0001, 1);
    chk(mft_oe, 3'b110);
    chk(32'(func_req), 32'h0000_0000);
    wr(SPACE_PCI, OFS_DEVICE_CONTROL, 32'h0000_0004);
    rd(SPACE_PCI, OFS_DEVICE_CONTROL, 32'h0000_0004, 1);
    chk(32'(func_req), 32'h0000_0001);
    chk(32'(csc_req), 32'h0000_0000);
    chk(mft_oe, 3'b110);
    $display("cardbus test done");
    results();
  end
endmodule
`default_nettype wire

// ===== verilog/pcim_irq_ctrl.sv
// card interrupt masking, flag reporting, clearing and routing
//
// Operation
// - each status-change source has its own mask
// - functional interrupts unmasked, always flagged and passed
// - change and functional interrupts routed separately
// - legacy masks at 05h, flags at 04h
// - functional flag at 91h bit 0
// - cardbus masks in socket mask, flags in event
// - legacy flags clear by write-one or read
// - clear mode at 1Eh bit 2, read default
// - cardbus flags clear only via force event
// - pure parallel mode drives first three terminals
// - signalling mode field in device control 92h
// - function 0 code 01h, function 1 02h
// - combined serial/parallel mode: function 1 reports 01h
// - reset mode is fully serialized delivery
// - functional events only for io or cardbus cards
// - power-up completion raises an internal event
`timescale 1ns/1ps
`default_nettype none
module pcim_irq_ctrl
  import pcim_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // card side
  input wire pcim_card_t card_type,
  input wire pcim_card_sig_t card_sig,
  input wire logic power_up_done,
  // register port
  input wire pcim_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // parallel interrupt terminals, open drain, low when driven
  output logic [2:0] multifunction_terminals_o,
  output logic [2:0] multifunction_terminals_oe,
  // requests towards the serial interrupt stream
  output logic serial_irq_stream_csc_req,
  output logic serial_irq_stream_func_req,
  // interrupt pin codes per function
  output logic [7:0] interrupt_pin_code_f0,
  output logic [7:0] interrupt_pin_code_f1
);

  // ****************************************
  // decode
  // ****************************************
  function automatic logic hit(input pcim_reg_req_t r, input logic [1:0] sp, input logic [7:0] ofs);
    hit = (r.space == sp) && (r.addr == ofs);
  endfunction

  function automatic logic [2:0] term_sel(input logic [1:0] route, input logic active);
    term_sel = 3'b000;
    if (active && route != 2'b11)
    begin
      term_sel[route] = 1'b1;
    end
  endfunction

  logic wr_leg_flags;
  logic rd_leg_flags;
  logic wr_leg_mask;
  logic wr_glob;
  logic wr_sock_mask;
  logic wr_force;
  logic wr_card_ctl;
  logic wr_dev_ctl;
  logic wr_route;

  assign wr_leg_flags = reg_req.wr && hit(reg_req, SPACE_LEGACY, OFS_LEGACY_CHANGE_FLAGS);
  assign rd_leg_flags = reg_req.rd && hit(reg_req, SPACE_LEGACY, OFS_LEGACY_CHANGE_FLAGS);
  assign wr_leg_mask = reg_req.wr && hit(reg_req, SPACE_LEGACY, OFS_LEGACY_CHANGE_IRQ_CONFIG);
  assign wr_glob = reg_req.wr && hit(reg_req, SPACE_LEGACY, OFS_LEGACY_GLOBAL_CONTROL);
  assign wr_sock_mask = reg_req.wr && hit(reg_req, SPACE_SOCKET, OFS_SOCKET_IRQ_MASK);
  assign wr_force = reg_req.wr && hit(reg_req, SPACE_SOCKET, OFS_SOCKET_FORCE_EVENT);
  assign wr_card_ctl = reg_req.wr && hit(reg_req, SPACE_PCI, OFS_CARD_CONTROL);
  assign wr_dev_ctl = reg_req.wr && hit(reg_req, SPACE_PCI, OFS_DEVICE_CONTROL);
  assign wr_route = reg_req.wr && hit(reg_req, SPACE_PCI, OFS_IRQ_ROUTE);

  // ****************************************
  // source edge detection
  // ****************************************
  pcim_card_sig_t sig_prev_reg;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sig_prev_reg <= '0;
    end
    else
    begin
      sig_prev_reg <= card_sig;
    end
  end

  logic is_mem16;
  logic is_io16;
  logic is_cardbus;
  logic [3:0] leg_set;
  logic [3:0] sock_set;
  logic func_set;

  assign is_mem16 = (card_type == CARD_MEM16);
  assign is_io16 = (card_type == CARD_IO16);
  assign is_cardbus = (card_type == CARD_CARDBUS);

  always_comb
  begin
    leg_set = 4'h0;
    sock_set = 4'h0;
    if (is_mem16)
    begin
      leg_set[LEG_BATT_ONE_BIT] = card_sig.battery_detect_one ^ sig_prev_reg.battery_detect_one;
      leg_set[LEG_BATT_TWO_BIT] = card_sig.battery_detect_two ^ sig_prev_reg.battery_detect_two;
      leg_set[LEG_READY_BIT] = card_sig.ready_or_request ^ sig_prev_reg.ready_or_request;
    end
    if (is_io16)
    begin
      leg_set[LEG_CARD16_STATUS_CHANGE_BIT] = card_sig.card16_status_change && !sig_prev_reg.card16_status_change;
    end
    if (is_mem16 || is_io16)
    begin
      leg_set[LEG_PWR_DONE_BIT] = power_up_done;
    end
    if (is_cardbus)
    begin
      sock_set[SOCK_CARD16_STATUS_CHANGE_BIT] = card_sig.cardbus_status_change && !sig_prev_reg.cardbus_status_change;
      sock_set[SOCK_PWR_DONE_BIT] = power_up_done;
    end
    // insertion and removal do not depend on the card type
    sock_set[SOCK_CD1_BIT] = card_sig.card_detect_one ^ sig_prev_reg.card_detect_one;
    sock_set[SOCK_CD2_BIT] = card_sig.card_detect_two ^ sig_prev_reg.card_detect_two;
  end

  // functional events from io and cardbus cards only
  always_comb
  begin
    func_set = 1'b0;
    if (is_io16)
    begin
      func_set = card_sig.ready_or_request && !sig_prev_reg.ready_or_request;
    end
    else if (is_cardbus)
    begin
      func_set = card_sig.cardbus_interrupt_request && !sig_prev_reg.cardbus_interrupt_request;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  logic [3:0] leg_mask_reg;
  logic [7:0] glob_ctl_reg;
  logic [3:0] sock_mask_reg;
  logic [7:0] dev_ctl_reg;
  logic [7:0] route_reg;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      leg_mask_reg <= MASK_RESET;
    end
    else if (wr_leg_mask)
    begin
      leg_mask_reg <= reg_req.wdata[3:0];
    end
  end

  // clear mode select, reset to read
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      glob_ctl_reg <= GLOBAL_CONTROL_RESET;
    end
    else if (wr_glob)
    begin
      glob_ctl_reg <= reg_req.wdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sock_mask_reg <= MASK_RESET;
    end
    else if (wr_sock_mask)
    begin
      sock_mask_reg <= reg_req.wdata[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dev_ctl_reg <= DEVICE_CONTROL_RESET;
    end
    else if (wr_dev_ctl)
    begin
      dev_ctl_reg <= reg_req.wdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      route_reg <= IRQ_ROUTE_RESET;
    end
    else if (wr_route)
    begin
      route_reg <= reg_req.wdata[7:0];
    end
  end

  // ****************************************
  // flags
  // ****************************************
  logic [3:0] leg_flags_reg;
  logic [3:0] sock_event_reg;
  logic [7:0] card_ctl_reg;
  logic clear_by_write;
  logic [3:0] leg_clr;

  assign clear_by_write = glob_ctl_reg[CLEAR_MODE_BIT];

  // clear by write-one or by read
  always_comb
  begin
    leg_clr = 4'h0;
    if (clear_by_write && wr_leg_flags)
    begin
      leg_clr = reg_req.wdata[3:0];
    end
    else if (!clear_by_write && rd_leg_flags)
    begin
      leg_clr = 4'hf;
    end
  end

  // a new event wins over a clear
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      leg_flags_reg <= FLAGS_RESET;
    end
    else
    begin
      leg_flags_reg <= (leg_flags_reg & ~leg_clr) | leg_set;
    end
  end

  // cleared only through force event writes
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sock_event_reg <= FLAGS_RESET;
    end
    else
    begin
      sock_event_reg <= (sock_event_reg & ~(wr_force ? reg_req.wdata[3:0] : 4'h0)) | sock_set;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      card_ctl_reg <= CARD_CONTROL_RESET;
    end
    else
    begin
      if (wr_card_ctl)
      begin
        card_ctl_reg[7:1] <= reg_req.wdata[7:1];
      end
      card_ctl_reg[CARD_FUNC_FLAG_BIT] <= (card_ctl_reg[CARD_FUNC_FLAG_BIT]
        && !(wr_card_ctl && reg_req.wdata[CARD_FUNC_FLAG_BIT])) || func_set;
    end
  end

  // ****************************************
  // interrupt signalling
  // ****************************************
  pcim_mode_t mode;
  logic csc_active;
  logic func_active;
  logic parallel_on;

  assign mode = pcim_mode_t'(dev_ctl_reg[MODE_LSB +: 2]);
  // level while any enabled flag is set
  assign csc_active = |(leg_flags_reg & leg_mask_reg) || |(sock_event_reg & sock_mask_reg);
  // no mask on the functional path
  assign func_active = card_ctl_reg[CARD_FUNC_FLAG_BIT];
  assign parallel_on = (mode == MODE_PARALLEL_ONLY) || (mode == MODE_SERIAL_IRQ_PAR_PCI);

  // parallel lines on the first three terminals
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      multifunction_terminals_oe <= 3'b000;
    end
    else if (parallel_on)
    begin
      multifunction_terminals_oe <= term_sel(route_reg[ROUTE_CSC_LSB +: 2], csc_active)
        | term_sel(route_reg[ROUTE_FUNC_LSB +: 2], func_active);
    end
    else
    begin
      multifunction_terminals_oe <= 3'b000;
    end
  end

  // open drain: only ever pull low
  assign multifunction_terminals_o = 3'b000;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      serial_irq_stream_csc_req <= 1'b0;
      serial_irq_stream_func_req <= 1'b0;
    end
    else
    begin
      serial_irq_stream_csc_req <= !parallel_on && csc_active;
      serial_irq_stream_func_req <= (mode != MODE_PARALLEL_ONLY) && func_active;
    end
  end

  // shared first interrupt in combined mode
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      interrupt_pin_code_f0 <= PIN_CODE_A;
      interrupt_pin_code_f1 <= PIN_CODE_B;
    end
    else
    begin
      interrupt_pin_code_f0 <= PIN_CODE_A;
      interrupt_pin_code_f1 <= (mode == MODE_SERIAL_IRQ_PAR_PCI) ? PIN_CODE_A : PIN_CODE_B;
    end
  end

  // ****************************************
  // read back
  // ****************************************
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (reg_req.space)
      SPACE_PCI:
      begin
        if (reg_req.addr == OFS_CARD_CONTROL)
          rd_mux = {24'h00_0000, card_ctl_reg};
        else if (reg_req.addr == OFS_DEVICE_CONTROL)
          rd_mux = {24'h00_0000, dev_ctl_reg};
        else if (reg_req.addr == OFS_IRQ_ROUTE)
          rd_mux = {24'h00_0000, route_reg};
      end
      SPACE_LEGACY:
      begin
        if (reg_req.addr == OFS_LEGACY_CHANGE_FLAGS)
          rd_mux = {28'h000_0000, leg_flags_reg};
        else if (reg_req.addr == OFS_LEGACY_CHANGE_IRQ_CONFIG)
          rd_mux = {28'h000_0000, leg_mask_reg};
        else if (reg_req.addr == OFS_LEGACY_GLOBAL_CONTROL)
          rd_mux = {24'h00_0000, glob_ctl_reg};
      end
      SPACE_SOCKET:
      begin
        if (reg_req.addr == OFS_SOCKET_IRQ_EVENT)
          rd_mux = {28'h000_0000, sock_event_reg};
        else if (reg_req.addr == OFS_SOCKET_IRQ_MASK)
          rd_mux = {28'h000_0000, sock_mask_reg};
      end
      default:
      begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // read data returns the value before any read clear takes effect
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd)
      begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// ===== verilog/pcim_pkg.sv
// constants and carrier types for the card interrupt mask and flag block
`default_nettype none
package pcim_pkg;

  // ****************************************
  // register access spaces and offsets
  // ****************************************
  localparam logic [1:0] SPACE_PCI = 2'h0;
  localparam logic [1:0] SPACE_LEGACY = 2'h1;
  localparam logic [1:0] SPACE_SOCKET = 2'h2;

  localparam logic [7:0] OFS_IRQ_ROUTE = 8'h8c;
  localparam logic [7:0] OFS_CARD_CONTROL = 8'h91;
  localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h92;
  localparam logic [7:0] OFS_LEGACY_CHANGE_FLAGS = 8'h04;
  localparam logic [7:0] OFS_LEGACY_CHANGE_IRQ_CONFIG = 8'h05;
  localparam logic [7:0] OFS_LEGACY_GLOBAL_CONTROL = 8'h1e;
  localparam logic [7:0] OFS_SOCKET_IRQ_EVENT = 8'h00;
  localparam logic [7:0] OFS_SOCKET_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFS_SOCKET_FORCE_EVENT = 8'h0c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int LEG_BATT_ONE_BIT = 0;
  localparam int LEG_BATT_TWO_BIT = 1;
  localparam int LEG_READY_BIT = 2;
  localparam int LEG_PWR_DONE_BIT = 3;
  localparam int LEG_CARD16_STATUS_CHANGE_BIT = 0;
  localparam int SOCK_CARD16_STATUS_CHANGE_BIT = 0;
  localparam int SOCK_CD1_BIT = 1;
  localparam int SOCK_CD2_BIT = 2;
  localparam int SOCK_PWR_DONE_BIT = 3;
  localparam int CARD_FUNC_FLAG_BIT = 0;
  localparam int CLEAR_MODE_BIT = 2;
  localparam int MODE_LSB = 1;
  localparam int ROUTE_CSC_LSB = 0;
  localparam int ROUTE_FUNC_LSB = 2;

  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [7:0] GLOBAL_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CARD_CONTROL_RESET = 8'h00;
  localparam logic [7:0] DEVICE_CONTROL_RESET = 8'h06;
  localparam logic [7:0] IRQ_ROUTE_RESET = 8'h04;
  localparam logic [7:0] PIN_CODE_A = 8'h01;
  localparam logic [7:0] PIN_CODE_B = 8'h02;

  typedef enum logic [1:0] {
    MODE_PARALLEL_ONLY = 2'b00,
    MODE_RESERVED = 2'b01,
    MODE_SERIAL_IRQ_PAR_PCI = 2'b10,
    MODE_SERIAL_ALL = 2'b11
  } pcim_mode_t;

  typedef enum logic [1:0] {
    CARD_NONE = 2'b00,
    CARD_MEM16 = 2'b01,
    CARD_IO16 = 2'b10,
    CARD_CARDBUS = 2'b11
  } pcim_card_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic battery_detect_one;
    logic battery_detect_two;
    logic ready_or_request;
    logic card16_status_change;
    logic cardbus_status_change;
    logic cardbus_interrupt_request;
    logic card_detect_one;
    logic card_detect_two;
  } pcim_card_sig_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] space;
    logic [7:0] addr;
    logic [31:0] wdata;
  } pcim_reg_req_t;

endpackage
`default_nettype wire
